// file: bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ucd_defs.vh"
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wr_data = 8'h00;
    logic reg_wr_stb = 1'b0;
    logic reg_rd_stb = 1'b0;
    logic send = 1'b0;
    logic multidrop = 1'b0;
    logic loopback = 1'b0;
    logic cts_b = 1'b0;
    wire [7:0] reg_rd_data_ff;
    wire [7:0] pulses;
    wire [4:0] lvl;
    wire bit_tick, tx_shift_busy;
    wire [7:0] lv = {3'h0, lvl};
    int fail_count = 0;
    int n_checks = 0;
    int i;
    always #4 clk = ~clk;
    ucd_serial_partner i_ucd_serial_partner (.clk(clk), .rst_b(rst_b), .send(send), .bit_tick(bit_tick),
        .tx_shift_busy(tx_shift_busy));
    ucd_command_decoder i_ucd_command_decoder (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rd_data_ff(reg_rd_data_ff),
        .tx_shift_busy(tx_shift_busy), .bit_tick(bit_tick), .cts_b(cts_b), .parity_mode_multidrop(multidrop),
        .local_loopback(loopback), .mode_ptr_reset_ff(pulses[`UCD_P_MODE_PTR]),
        .rx_fifo_reset_ff(pulses[`UCD_P_RX_RESET]), .tx_flags_clr_ff(pulses[`UCD_P_TX_FLAGS_CLR]),
        .err_flags_clr_ff(pulses[`UCD_P_ERR_CLR]), .delta_break_clr_ff(pulses[`UCD_P_DBRK_CLR]),
        .tx_flags_set_ff(pulses[`UCD_P_TX_FLAGS_SET]), .rx_search_start_ff(pulses[`UCD_P_RX_SEARCH]),
        .rx_drop_char_ff(pulses[`UCD_P_RX_DROP]), .tx_enable_ff(lvl[0]), .rx_enable_ff(lvl[1]), .rx_run_ff(lvl[2]),
        .txd_break_ff(lvl[3]), .tx_hold_inhibit_ff(lvl[4]));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // bit 7 and control code 11 are never written
    task automatic cmd(input logic [7:0] data, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= `UCD_OFS_COMMAND;
        reg_wr_data <= data;
        reg_wr_stb <= 1'b1;
        @(posedge clk);
        reg_wr_stb <= 1'b0;
        #1 check(pulses, exp);
        @(posedge clk);
        #1 check(pulses, 8'h00);
    endtask
    task automatic rd(input logic [3:0] addr, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= addr;
        reg_rd_stb <= 1'b1;
        @(posedge clk);
        reg_rd_stb <= 1'b0;
        #1 check(reg_rd_data_ff, exp);
    endtask
    task automatic wait_lv(input int b, input logic v, input int bound);
        int k;
        for (k = 0; k < bound && lv[b] !== v; k++)
            @(posedge clk) #1;
        check({7'h0, lv[b]}, {7'h0, v});
        if (lv[b] !== v)
            give_verdict();
    endtask
    task automatic one_char;
        @(posedge clk);
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1 check(lv | pulses, 8'h00);
        for (i = 0; i <= 5; i++)
            cmd({1'b0, i[2:0], 4'h0}, (i == 0) ? 8'h00 : 8'h01 << (i - 1));
        $display("misc codes done");
        cmd(8'h04, 8'h01 << `UCD_P_TX_FLAGS_SET);
        rd(`UCD_OFS_STATE, 8'h01);
        rd(`UCD_OFS_COMMAND, 8'h00);
        rd(4'hF, 8'h00);
        cmd(8'h04, 8'h00);
        one_char();
        cmd(8'h08, 8'h01 << `UCD_P_TX_FLAGS_CLR);
        check(lv, 8'h01);
        wait_lv(0, 1'b0, 400);
        check({7'h0, tx_shift_busy}, 8'h00);
        cmd(8'h08, 8'h00);
        cmd(8'h34, 8'h01 << `UCD_P_TX_FLAGS_CLR);
        check(lv, 8'h00);
        $display("transmitter control done");
        cmd(8'h01, 8'h01 << `UCD_P_RX_SEARCH);
        check(lv, 8'h06);
        cmd(8'h01, 8'h00);
        cmd(8'h02, 8'h01 << `UCD_P_RX_DROP);
        cmd(8'h02, 8'h00);
        check(lv, 8'h00);
        @(posedge clk);
        multidrop <= 1'b1;
        cmd(8'h01, 8'h00);
        check(lv, 8'h04);
        @(posedge clk);
        multidrop <= 1'b0;
        loopback <= 1'b1;
        cmd(8'h01, 8'h01 << `UCD_P_RX_SEARCH);
        cmd(8'h20, 8'h01 << `UCD_P_RX_RESET);
        check(lv, 8'h04);
        @(posedge clk);
        loopback <= 1'b0;
        cts_b <= 1'b1; // negated from here on: break must not care
        $display("receiver control done");
        cmd(8'h60, 8'h00);
        check(lv, 8'h00);
        cmd(8'h04, 8'h01 << `UCD_P_TX_FLAGS_SET);
        one_char();
        cmd(8'h60, 8'h00);
        check(lv, 8'h11);
        wait_lv(3, 1'b1, 400);
        check({7'h0, tx_shift_busy}, 8'h00);
        cmd(8'h70, 8'h00);
        wait_lv(3, 1'b0, 32);
        check(lv, 8'h01);
        $display("break done");
        cmd(8'h05, 8'h01 << `UCD_P_RX_SEARCH);
        check(lv, 8'h07);
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        #1 check(lv | pulses, 8'h00);
        $display("mid-run reset done");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire

// file: bench/ucd_cmd_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "ucd_defs.vh"
module ucd_cmd_properties
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [`UCD_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_wr_stb,
    input wire logic reg_rd_stb,
    input wire logic [7:0] reg_rd_data_ff,
    // far side and modes
    input wire logic tx_shift_busy,
    input wire logic bit_tick,
    input wire logic parity_mode_multidrop,
    // outputs watched
    input wire logic mode_ptr_reset_ff,
    input wire logic rx_fifo_reset_ff,
    input wire logic tx_flags_clr_ff,
    input wire logic delta_break_clr_ff,
    input wire logic tx_flags_set_ff,
    input wire logic rx_search_start_ff,
    input wire logic rx_drop_char_ff,
    input wire logic tx_enable_ff,
    input wire logic rx_enable_ff,
    input wire logic txd_break_ff,
    input wire logic tx_hold_inhibit_ff
);
    wire cmd_wr = reg_wr_stb && reg_addr == `UCD_OFS_COMMAND;
    wire [2:0] misc = reg_wr_data[6:4];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_mode_ptr_pulse: assert property (
        mode_ptr_reset_ff == $past(cmd_wr && misc == `UCD_MISC_MODE_PTR))
        else $error("mode pointer pulse wrong");
    a_dbrk_clr_pulse: assert property (delta_break_clr_ff == $past(cmd_wr && misc == `UCD_MISC_DBRK_RESET))
        else $error("delta break pulse wrong");
    a_rx_reset_stop: assert property (cmd_wr && misc == `UCD_MISC_RX_RESET
        |=> rx_fifo_reset_ff && !rx_enable_ff)
        else $error("receiver reset wrong");
    a_tx_reset_wins: assert property (cmd_wr && misc == `UCD_MISC_TX_RESET
        |=> tx_flags_clr_ff && !tx_enable_ff && !tx_flags_set_ff)
        else $error("transmitter reset wrong");
    a_tx_enable_on: assert property (cmd_wr && reg_wr_data[3:2] == `UCD_CTL_ENABLE
        && misc != `UCD_MISC_TX_RESET && !tx_enable_ff |=> tx_enable_ff && tx_flags_set_ff)
        else $error("transmitter enable wrong");
    a_rx_enable_on: assert property (cmd_wr && reg_wr_data[1:0] == `UCD_CTL_ENABLE
        && misc != `UCD_MISC_RX_RESET && !parity_mode_multidrop && !rx_enable_ff
        |=> rx_enable_ff && rx_search_start_ff)
        else $error("receiver enable wrong");
    a_rx_drop_off: assert property (cmd_wr && reg_wr_data[1:0] == `UCD_CTL_DISABLE
        && misc != `UCD_MISC_RX_RESET && rx_enable_ff |=> rx_drop_char_ff && !rx_enable_ff)
        else $error("receiver disable wrong");
    a_break_wait_shift: assert property ($rose(txd_break_ff) |-> $past(bit_tick && !tx_shift_busy))
        else $error("break started mid character");
    a_break_needs_tx: assert property (cmd_wr && misc == `UCD_MISC_BRK_START
        && !tx_enable_ff && !tx_hold_inhibit_ff |=> !tx_hold_inhibit_ff && !txd_break_ff)
        else $error("break taken with transmitter off");
    a_break_stop_bound: assert property (cmd_wr && misc == `UCD_MISC_BRK_STOP && txd_break_ff
        |=> ##[0:32] !txd_break_ff)
        else $error("break not stopped in two bit times");
    a_cmd_read_zero: assert property (reg_rd_stb && reg_addr == `UCD_OFS_COMMAND
        |=> reg_rd_data_ff == 8'h00)
        else $error("command register read back");
endmodule // ucd_cmd_properties
bind ucd_command_decoder ucd_cmd_properties i_ucd_cmd_properties (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rd_data_ff(reg_rd_data_ff),
    .tx_shift_busy(tx_shift_busy), .bit_tick(bit_tick), .parity_mode_multidrop(parity_mode_multidrop),
    .mode_ptr_reset_ff(mode_ptr_reset_ff), .rx_fifo_reset_ff(rx_fifo_reset_ff), .tx_flags_clr_ff(tx_flags_clr_ff),
    .delta_break_clr_ff(delta_break_clr_ff), .tx_flags_set_ff(tx_flags_set_ff),
    .rx_search_start_ff(rx_search_start_ff), .rx_drop_char_ff(rx_drop_char_ff), .tx_enable_ff(tx_enable_ff),
    .rx_enable_ff(rx_enable_ff), .txd_break_ff(txd_break_ff), .tx_hold_inhibit_ff(tx_hold_inhibit_ff));
`default_nettype wire

// file: bench/ucd_serial_partner.sv
`timescale 1ns/100ps
`default_nettype none
module ucd_serial_partner
#(
    parameter int TICK = 16
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // start one ten-bit character
    input wire logic send,
    // transmitter side status
    output logic bit_tick,
    output logic tx_shift_busy
);
    logic [7:0] div_ff;
    logic [3:0] bits_ff;
    // bit clock runs free, as the channel's baud divider does
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_ff <= 8'h00;
            bits_ff <= 4'h0;
        end
        else
        begin
            div_ff <= bit_tick ? 8'h00 : div_ff + 8'h01;
            if (send)
                bits_ff <= 4'hA;
            else if (bit_tick && bits_ff != 4'h0)
                bits_ff <= bits_ff - 4'h1;
        end
    end
    assign bit_tick = div_ff == 8'(TICK - 1);
    assign tx_shift_busy = bits_ff != 4'h0;
endmodule // ucd_serial_partner
`default_nettype wire

// file: hw/ucd_command_decoder.v
// Operation
// RQ1 - software writes zero to reserved bit 7; hardware ignores it
// RQ2 - one write carries only non-conflicting commands; resets win over enables
// RQ3 - bits 6 to 4 hold one miscellaneous command; code 000 does nothing
// RQ4 - code 001 points the mode register pointer at the first mode register
// RQ5 - code 010 disables receiver, clears fifo-full and receiver-ready, resets pointer
// RQ6 - software prefers receiver reset over receiver disable when reconfiguring
// RQ7 - code 011 disables transmitter, clears transmitter-empty and transmitter-ready
// RQ8 - code 100 clears received-break, framing, parity and overrun flags
// RQ9 - code 101 clears the delta-break flag
// RQ10 - code 110 drives serial output low; may lag one bit time
// RQ11 - break waits for shift register; held character goes after break
// RQ12 - start break accepted only with transmitter enabled, ignoring clear-to-send
// RQ13 - code 111 returns output to mark within two bit times
// RQ14 - bits 3 to 2 select transmitter command; 00 keeps current state
// RQ15 - transmitter enable sets empty and ready flags; no effect if enabled
// RQ16 - transmitter disable clears flags, finishes current character; no effect if disabled
// RQ17 - software never writes transmitter control code 11
// RQ18 - receiver enable searches start bit unless multidrop; no effect if enabled
// RQ19 - receiver disable drops partial character; loop-back or multidrop keeps receiving
// RQ20 - commands act as one-cycle pulses; command register reads back zero
`timescale 1ns/100ps
`default_nettype none
`include "ucd_defs.vh"

module ucd_command_decoder
(
    // clock and reset
    input wire clk,
    input wire rst_b,
    // register port
    input wire [`UCD_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wr_data,
    input wire reg_wr_stb,
    input wire reg_rd_stb,
    output reg [7:0] reg_rd_data_ff,
    // transmitter side status
    input wire tx_shift_busy,
    input wire bit_tick,
    input wire cts_b,
    // receiver side mode
    input wire parity_mode_multidrop,
    input wire local_loopback,
    // command pulses
    output wire mode_ptr_reset_ff,
    output wire rx_fifo_reset_ff,
    output wire tx_flags_clr_ff,
    output wire err_flags_clr_ff,
    output wire delta_break_clr_ff,
    output wire tx_flags_set_ff,
    output wire rx_search_start_ff,
    output wire rx_drop_char_ff,
    // levels
    output reg tx_enable_ff,
    output reg rx_enable_ff,
    output reg rx_run_ff,
    output reg txd_break_ff,
    output reg tx_hold_inhibit_ff
);

    // break sequencer states
    localparam BRK_IDLE = 4'b0001;
    localparam BRK_WAIT = 4'b0010;
    localparam BRK_ACTIVE = 4'b0100;
    localparam BRK_STOPPING = 4'b1000;

    reg [3:0] brk_state_ff;
    reg [3:0] nxt_brk_state;
    reg nxt_txd_break;
    reg tx_stop_pend_ff;
    reg nxt_tx_stop_pend;
    reg nxt_tx_enable;
    reg nxt_rx_enable;
    reg [`UCD_PULSE_W-1:0] nxt_pulse;
    reg [7:0] nxt_rd_data;
    reg nxt_rx_run;
    reg nxt_tx_hold_inhibit;
    reg cmd_sel;
    reg state_sel;

    wire cmd_wr;
    wire [2:0] misc_code;
    wire [1:0] tc_code;
    wire [1:0] rc_code;
    wire rx_reset_cmd;
    wire tx_reset_cmd;
    wire brk_start_cmd;
    wire brk_stop_cmd;
    wire tx_en_cmd;
    wire tx_dis_cmd;
    wire rx_en_cmd;
    wire rx_dis_cmd;
    wire [`UCD_PULSE_W-1:0] pulse_vec;
    wire brk_pending;
    wire [7:0] state_word;

    // address decode; unmapped offsets select nothing
    always @*
    begin
        cmd_sel = 1'b0;
        state_sel = 1'b0;
        if (reg_addr == `UCD_OFS_COMMAND)
        begin
            cmd_sel = 1'b1;
        end
        else if (reg_addr == `UCD_OFS_STATE)
        begin
            state_sel = 1'b1;
        end
    end

    // command decode; bit 7 is simply not looked at [RQ1]
    assign cmd_wr = reg_wr_stb && cmd_sel;
    assign misc_code = reg_wr_data[`UCD_MISC_HI:`UCD_MISC_LO]; // [RQ3]
    assign tc_code = reg_wr_data[`UCD_TC_HI:`UCD_TC_LO]; // [RQ14]
    assign rc_code = reg_wr_data[`UCD_RC_HI:`UCD_RC_LO];

    assign rx_reset_cmd = cmd_wr && (misc_code == `UCD_MISC_RX_RESET);
    assign tx_reset_cmd = cmd_wr && (misc_code == `UCD_MISC_TX_RESET);
    assign brk_start_cmd = cmd_wr && (misc_code == `UCD_MISC_BRK_START);
    assign brk_stop_cmd = cmd_wr && (misc_code == `UCD_MISC_BRK_STOP);

    // code 11 matches neither compare, so it is ignored [RQ17]
    assign tx_en_cmd = cmd_wr && (tc_code == `UCD_CTL_ENABLE);
    assign tx_dis_cmd = cmd_wr && (tc_code == `UCD_CTL_DISABLE);
    assign rx_en_cmd = cmd_wr && (rc_code == `UCD_CTL_ENABLE);
    assign rx_dis_cmd = cmd_wr && (rc_code == `UCD_CTL_DISABLE);

    // one-shot command pulses
    always @*
    begin
        nxt_pulse = `UCD_RST_PULSES;
        if (cmd_wr)
        begin
            // 000 raises none of the miscellaneous-code pulses [RQ3]
            nxt_pulse[`UCD_P_MODE_PTR] = (misc_code == `UCD_MISC_MODE_PTR); // [RQ4]
            nxt_pulse[`UCD_P_RX_RESET] = rx_reset_cmd; // [RQ5]
            nxt_pulse[`UCD_P_ERR_CLR] = (misc_code == `UCD_MISC_ERR_RESET); // [RQ8]
            nxt_pulse[`UCD_P_DBRK_CLR] = (misc_code == `UCD_MISC_DBRK_RESET); // [RQ9]
            // flags clear on reset or on a real disable [RQ7] [RQ16]
            nxt_pulse[`UCD_P_TX_FLAGS_CLR] = tx_reset_cmd || (tx_dis_cmd && tx_enable_ff);
            // a reset in the same write beats the enable [RQ2]
            nxt_pulse[`UCD_P_TX_FLAGS_SET] = tx_en_cmd && !tx_reset_cmd && !tx_enable_ff; // [RQ15]
            nxt_pulse[`UCD_P_RX_SEARCH] = rx_en_cmd && !rx_reset_cmd && !rx_enable_ff
                && !parity_mode_multidrop; // [RQ18]
            // partial character is dropped, status left alone [RQ19]
            nxt_pulse[`UCD_P_RX_DROP] = rx_dis_cmd && rx_enable_ff;
        end
    end

    // pulses last exactly one cycle [RQ20]
    ucd_pulse_reg
    #(
        .WIDTH(`UCD_PULSE_W)
    )
    u_pulse
    (
        .clk(clk),
        .rst_b(rst_b),
        .nxt_pulse(nxt_pulse),
        .pulse_ff(pulse_vec)
    );

    assign mode_ptr_reset_ff = pulse_vec[`UCD_P_MODE_PTR];
    assign rx_fifo_reset_ff = pulse_vec[`UCD_P_RX_RESET];
    assign tx_flags_clr_ff = pulse_vec[`UCD_P_TX_FLAGS_CLR];
    assign err_flags_clr_ff = pulse_vec[`UCD_P_ERR_CLR];
    assign delta_break_clr_ff = pulse_vec[`UCD_P_DBRK_CLR];
    assign tx_flags_set_ff = pulse_vec[`UCD_P_TX_FLAGS_SET];
    assign rx_search_start_ff = pulse_vec[`UCD_P_RX_SEARCH];
    assign rx_drop_char_ff = pulse_vec[`UCD_P_RX_DROP];

    // transmitter enable and graceful stop
    always @*
    begin
        nxt_tx_enable = tx_enable_ff;
        nxt_tx_stop_pend = tx_stop_pend_ff;
        if (tx_reset_cmd)
        begin
            // reset stops at once, not waiting for the shifter [RQ7] [RQ2]
            nxt_tx_enable = 1'b0;
            nxt_tx_stop_pend = 1'b0;
        end
        else if (tx_en_cmd)
        begin
            // enable also cancels a disable still waiting [RQ15]
            nxt_tx_enable = 1'b1;
            nxt_tx_stop_pend = 1'b0;
        end
        else if (tx_dis_cmd && tx_enable_ff)
        begin
            nxt_tx_stop_pend = 1'b1; // [RQ16]
        end
        else if (tx_stop_pend_ff && !tx_shift_busy)
        begin
            // character in flight has finished [RQ16]
            nxt_tx_enable = 1'b0;
            nxt_tx_stop_pend = 1'b0;
        end
    end

    // receiver enable
    always @*
    begin
        nxt_rx_enable = rx_enable_ff;
        if (rx_reset_cmd)
        begin
            nxt_rx_enable = 1'b0; // [RQ5] [RQ2]
        end
        else if (rx_en_cmd && !parity_mode_multidrop)
        begin
            nxt_rx_enable = 1'b1; // [RQ18]
        end
        else if (rx_dis_cmd)
        begin
            nxt_rx_enable = 1'b0; // [RQ19]
        end
    end

    // loop-back and multidrop keep the receiver running despite a disable [RQ19]
    always @*
    begin
        nxt_rx_run = nxt_rx_enable;
        if (local_loopback)
        begin
            nxt_rx_run = 1'b1;
        end
        else if (parity_mode_multidrop)
        begin
            nxt_rx_run = 1'b1;
        end
    end

    // break sequencer; clear-to-send is deliberately not an input here [RQ12]
    always @*
    begin
        nxt_brk_state = brk_state_ff;
        nxt_txd_break = txd_break_ff;
        case (brk_state_ff)
            BRK_IDLE:
            begin
                if (brk_start_cmd && tx_enable_ff)
                begin
                    nxt_brk_state = BRK_WAIT; // [RQ12]
                end
            end
            BRK_WAIT:
            begin
                if (brk_stop_cmd)
                begin
                    nxt_brk_state = BRK_IDLE;
                end
                else if (!tx_shift_busy && bit_tick)
                begin
                    // lands on a bit boundary, so up to one bit late [RQ10] [RQ11]
                    nxt_brk_state = BRK_ACTIVE;
                    nxt_txd_break = 1'b1;
                end
            end
            BRK_ACTIVE:
            begin
                if (brk_stop_cmd)
                begin
                    nxt_brk_state = BRK_STOPPING; // [RQ13]
                end
            end
            BRK_STOPPING:
            begin
                if (brk_start_cmd && tx_enable_ff)
                begin
                    nxt_brk_state = BRK_ACTIVE;
                end
                else if (bit_tick)
                begin
                    // mark returns within one bit time, inside the two allowed [RQ13]
                    nxt_brk_state = BRK_IDLE;
                    nxt_txd_break = 1'b0;
                end
            end
            default:
            begin
                nxt_brk_state = BRK_IDLE;
                nxt_txd_break = 1'b0;
            end
        endcase
        // holding register waits until the break is over [RQ11]
        nxt_tx_hold_inhibit = (nxt_brk_state != BRK_IDLE);
    end

    // status word of the read-only state register
    assign brk_pending = brk_state_ff[1] | brk_state_ff[3];
    assign state_word[7] = 1'b0;
    assign state_word[6] = tx_hold_inhibit_ff;
    assign state_word[5] = txd_break_ff;
    assign state_word[4] = brk_pending;
    assign state_word[3] = tx_stop_pend_ff;
    assign state_word[2] = rx_run_ff;
    assign state_word[1] = rx_enable_ff;
    assign state_word[0] = tx_enable_ff;

    // read path; the command register is write only [RQ20]
    always @*
    begin
        nxt_rd_data = `UCD_RST_STATE_RD;
        if (reg_rd_stb)
        begin
            if (state_sel)
            begin
                nxt_rd_data = state_word;
            end
            else
            begin
                nxt_rd_data = `UCD_RST_STATE_RD;
            end
        end
    end

    // state registers
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_enable_ff <= 1'b0;
            tx_stop_pend_ff <= 1'b0;
            rx_enable_ff <= 1'b0;
            rx_run_ff <= 1'b0;
            brk_state_ff <= BRK_IDLE;
            txd_break_ff <= 1'b0;
            tx_hold_inhibit_ff <= 1'b0;
            reg_rd_data_ff <= `UCD_RST_STATE_RD;
        end
        else
        begin
            tx_enable_ff <= nxt_tx_enable;
            tx_stop_pend_ff <= nxt_tx_stop_pend;
            rx_enable_ff <= nxt_rx_enable;
            rx_run_ff <= nxt_rx_run; // [RQ19]
            brk_state_ff <= nxt_brk_state;
            txd_break_ff <= nxt_txd_break;
            tx_hold_inhibit_ff <= nxt_tx_hold_inhibit; // [RQ11]
            reg_rd_data_ff <= nxt_rd_data;
        end
    end

endmodule // ucd_command_decoder

`default_nettype wire

// file: hw/ucd_defs.vh
`ifndef UCD_DEFS_VH
`define UCD_DEFS_VH

// register map, word offsets on the plain register port
`define UCD_ADDR_W 4
`define UCD_OFS_COMMAND 4'h0
`define UCD_OFS_STATE 4'h4

// channel_command field positions
`define UCD_CMD_RSVD_BIT 7
`define UCD_MISC_HI 6
`define UCD_MISC_LO 4
`define UCD_TC_HI 3
`define UCD_TC_LO 2
`define UCD_RC_HI 1
`define UCD_RC_LO 0

// miscellaneous field codes
`define UCD_MISC_NONE 3'h0
`define UCD_MISC_MODE_PTR 3'h1
`define UCD_MISC_RX_RESET 3'h2
`define UCD_MISC_TX_RESET 3'h3
`define UCD_MISC_ERR_RESET 3'h4
`define UCD_MISC_DBRK_RESET 3'h5
`define UCD_MISC_BRK_START 3'h6
`define UCD_MISC_BRK_STOP 3'h7

// transmitter and receiver control codes
`define UCD_CTL_NONE 2'h0
`define UCD_CTL_ENABLE 2'h1
`define UCD_CTL_DISABLE 2'h2
`define UCD_CTL_RSVD 2'h3

// command pulse vector bit positions
`define UCD_PULSE_W 8
`define UCD_P_MODE_PTR 0
`define UCD_P_RX_RESET 1
`define UCD_P_TX_FLAGS_CLR 2
`define UCD_P_ERR_CLR 3
`define UCD_P_DBRK_CLR 4
`define UCD_P_TX_FLAGS_SET 5
`define UCD_P_RX_SEARCH 6
`define UCD_P_RX_DROP 7

// reset values
`define UCD_RST_PULSES 8'h00
`define UCD_RST_STATE_RD 8'h00

`endif

// file: hw/ucd_pulse_reg.v
`timescale 1ns/100ps
`default_nettype none

module ucd_pulse_reg
#(
    parameter WIDTH = 8
)
(
    // clock and reset
    input wire clk,
    input wire rst_b,
    // pulse requests, one cycle each
    input wire [WIDTH-1:0] nxt_pulse,
    // registered pulses
    output reg [WIDTH-1:0] pulse_ff
);

    // registering keeps every command output glitch free
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pulse_ff <= {WIDTH{1'b0}};
        end
        else
        begin
            pulse_ff <= nxt_pulse;
        end
    end

endmodule // ucd_pulse_reg

`default_nettype wire
